//--- twmr_consts.vh
// Purpose: Constants of the two-wire master receiver
// Assumes: 200 MHz hclk, byte offsets on a 32-bit AHB-Lite bus
// Notes: Status codes are full bytes with prescaler bits zero
`ifndef TWMR_CONSTS_VH
`define TWMR_CONSTS_VH
// Register byte offsets
`define TWMR_OFF_CTRL 8'h00
`define TWMR_OFF_STAT 8'h04
`define TWMR_OFF_DATA 8'h08
`define TWMR_OFF_ISTAT 8'h0c
`define TWMR_OFF_IMASK 8'h10
// Control field positions
`define TWMR_CB_DONE 7
`define TWMR_CB_ACK 6
`define TWMR_CB_STA 5
`define TWMR_CB_STO 4
`define TWMR_CB_WCOL 3
`define TWMR_CB_EN 2
`define TWMR_CB_IE 0
// Interrupt status bit positions
`define TWMR_IB_DONE 0
`define TWMR_IB_ARB 1
`define TWMR_IB_STOP 2
// Reset values
`define TWMR_CTRL_RST 8'h00
`define TWMR_DATA_RST 8'hff
`define TWMR_IMASK_RST 3'h0
// Status codes
`define TWMR_SC_START 8'h08
`define TWMR_SC_RSTART 8'h10
`define TWMR_SC_WACK 8'h18
`define TWMR_SC_WNACK 8'h20
`define TWMR_SC_ARB 8'h38
`define TWMR_SC_RACK 8'h40
`define TWMR_SC_RNACK 8'h48
`define TWMR_SC_DACK 8'h50
`define TWMR_SC_DNACK 8'h58
`define TWMR_SC_IDLE 8'hf8
// Timing: quarter of a bus bit
`define TWMR_QTR_NS 2500
`define TWMR_CLK_MHZ 200
`define TWMR_QTR_CYC ((`TWMR_QTR_NS * `TWMR_CLK_MHZ) / 1000)
`define TWMR_CNT_W 9
`endif

//--- twmr_top.v
// Purpose: Two-wire bus master receiver with AHB-Lite registers
// Assumes: Open-drain pins, single slave on the AHB-Lite bus
// Notes: Bus clock is a fixed quarter-bit divider of hclk
// How it works
// [RULE1] Start request: done one, start, enable
// [RULE2] Start condition only once bus is free
// [RULE3] After start: flag set, status 0x08
// [RULE4] Address direction bit picks receiver or transmitter; code only stores it, with no transmit path after 0x18/0x20
// [RULE5] Load read address, then clear flag
// [RULE6] After address ack: 0x38, 0x40 or 0x48
// [RULE7] Received byte readable while flag set
// [RULE8] Software sends NACK on last byte
// [RULE9] Stop request: done one, stop, enable
// [RULE10] Repeated start reports 0x10, keeps bus
// [RULE11] In 0x10 address direction switches mode
// [RULE12] On 0x38 release bus or restart
// [RULE13] In 0x40/0x50 receive byte, ack per enable
// [RULE14] In 0x48/0x58 restart, stop, or both
// [RULE15] Hardware clears stop request after stop
// [RULE16] Software reads byte before clearing flag
// [RULE17] Status codes assume prescaler bits zero
// [RULE18] Action writes keep enable and done one
// [RULE19] Flag set holds clock low, no action; after arbitration loss (0x38) the clock is released
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`include "twmr_consts.vh"
module twmr_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe_n,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe_n,
  output wire irq
);
  localparam S_IDLE = 5'h01;
  localparam S_START = 5'h02;
  localparam S_BYTE = 5'h04;
  localparam S_STOP = 5'h08;
  localparam S_HOLD = 5'h10;
  localparam integer QTR_CYC = `TWMR_QTR_CYC - 1;
  localparam [`TWMR_CNT_W-1:0] QTR_MAX = QTR_CYC[`TWMR_CNT_W-1:0];
  localparam [7:0] CTRL_RST = `TWMR_CTRL_RST;

  reg a_sel_reg, a_wr_reg;
  reg [7:0] a_adr_reg;
  reg [31:0] hrdata_reg;
  reg done_reg, ack_en_reg, sta_reg, sto_reg, wcol_reg, en_reg, ie_reg;
  reg [1:0] presc_reg;
  reg [7:0] data_reg, code_reg, sh_reg;
  reg [2:0] istat_reg, imask_reg;
  reg [4:0] st_reg;
  reg [1:0] ph_reg;
  reg [3:0] bit_reg;
  reg [`TWMR_CNT_W-1:0] div_reg;
  reg tick_reg, scl_low_reg, sda_low_reg, owned_reg, busy_reg;
  reg tx_reg, addr_reg, rx_mode_reg, ack_bit_reg, restart_reg;
  reg [2:0] scl_sy_reg, sda_sy_reg;
  reg scl_f_reg, sda_f_reg, scl_p_reg, sda_p_reg;
  reg [2:0] ev_reg;
  reg [31:0] rd;
  wire take, wr_ctrl, wr_data, wr_stat, wr_imask, go;
  wire w_sta, w_sto, w_ack, drv_one;
  wire [2:0] istat_next;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~scl_low_reg;
  assign sda_oe_n = ~sda_low_reg;
  assign irq = |(istat_reg & imask_reg);

  assign take = hready & hsel & htrans[1];
  assign wr_ctrl = a_sel_reg & a_wr_reg & (a_adr_reg == `TWMR_OFF_CTRL);
  assign wr_data = a_sel_reg & a_wr_reg & (a_adr_reg == `TWMR_OFF_DATA);
  assign wr_stat = a_sel_reg & a_wr_reg & (a_adr_reg == `TWMR_OFF_STAT);
  assign wr_imask = a_sel_reg & a_wr_reg & (a_adr_reg == `TWMR_OFF_IMASK);
  assign w_sta = hwdata[`TWMR_CB_STA];
  assign w_sto = hwdata[`TWMR_CB_STO];
  assign w_ack = hwdata[`TWMR_CB_ACK];
  // A bus action needs done and enable written as one
  assign go = wr_ctrl & hwdata[`TWMR_CB_DONE] & hwdata[`TWMR_CB_EN] &
    (st_reg == S_IDLE || st_reg == S_HOLD); // [RULE1] [RULE18]
  // Transmitted one: arbitration is lost if the line reads low
  assign drv_one = tx_reg ? (bit_reg != 4'h8 && sh_reg[7]) :
    (bit_reg == 4'h8 && !ack_en_reg);
  // Event sets win over the read clear
  assign istat_next = ev_reg | ((take && !hwrite &&
    haddr[7:0] == `TWMR_OFF_ISTAT) ? 3'h0 : istat_reg);

  always @* begin
    case (haddr[7:0])
      `TWMR_OFF_CTRL: rd = {24'h0, done_reg, ack_en_reg, sta_reg, sto_reg,
        wcol_reg, en_reg, 1'b0, ie_reg};
      `TWMR_OFF_STAT: rd = {24'h0, code_reg[7:3], 1'b0, presc_reg};
      `TWMR_OFF_DATA: rd = {24'h0, data_reg}; // [RULE7]
      `TWMR_OFF_ISTAT: rd = {29'h0, istat_reg};
      `TWMR_OFF_IMASK: rd = {29'h0, imask_reg};
      default: rd = 32'h0;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {a_sel_reg, a_wr_reg, a_adr_reg} <= 10'h000;
      hrdata_reg <= 32'h0;
      {done_reg, ack_en_reg, sta_reg, sto_reg} <= CTRL_RST[7:4];
      {wcol_reg, en_reg} <= CTRL_RST[3:2];
      ie_reg <= CTRL_RST[0];
      {istat_reg, presc_reg} <= 5'h00;
      {data_reg, code_reg} <= {`TWMR_DATA_RST, `TWMR_SC_IDLE};
      imask_reg <= `TWMR_IMASK_RST;
      st_reg <= S_IDLE;
      {ph_reg, bit_reg} <= 6'h00;
      sh_reg <= 8'h00;
      {div_reg, tick_reg} <= {(`TWMR_CNT_W+1){1'b0}};
      {scl_low_reg, sda_low_reg, owned_reg, busy_reg} <= 4'h0;
      {ev_reg, tx_reg, addr_reg} <= 5'h00;
      {rx_mode_reg, ack_bit_reg, restart_reg} <= 3'h0;
      {scl_sy_reg, sda_sy_reg} <= 6'h3f;
      {scl_f_reg, sda_f_reg, scl_p_reg, sda_p_reg} <= 4'hf;
    end else begin
      a_sel_reg <= take;
      a_wr_reg <= hwrite;
      a_adr_reg <= haddr[7:0];
      if (take && !hwrite)
        hrdata_reg <= rd;
      istat_reg <= istat_next;
      // Pin synchronisers, a change counts once stages two and three agree
      scl_sy_reg <= {scl_sy_reg[1:0], scl_i};
      sda_sy_reg <= {sda_sy_reg[1:0], sda_i};
      if (scl_sy_reg[1] == scl_sy_reg[2])
        scl_f_reg <= scl_sy_reg[2];
      if (sda_sy_reg[1] == sda_sy_reg[2])
        sda_f_reg <= sda_sy_reg[2];
      scl_p_reg <= scl_f_reg;
      sda_p_reg <= sda_f_reg;
      // Bus busy between any start and stop seen on the wires
      if (scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg)
        busy_reg <= 1'b1;
      else if (scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg)
        busy_reg <= 1'b0;
      tick_reg <= (div_reg == QTR_MAX);
      div_reg <= (div_reg == QTR_MAX) ? {`TWMR_CNT_W{1'b0}} :
        div_reg + 1'b1;
      // Register writes
      if (wr_ctrl) begin
        ack_en_reg <= w_ack;
        sta_reg <= w_sta;
        sto_reg <= w_sto;
        en_reg <= hwdata[`TWMR_CB_EN];
        ie_reg <= hwdata[`TWMR_CB_IE];
        if (hwdata[`TWMR_CB_DONE])
          done_reg <= 1'b0;
      end
      if (wr_stat)
        presc_reg <= hwdata[1:0]; // [RULE17]
      if (wr_imask)
        imask_reg <= hwdata[2:0];
      if (wr_data) begin
        if (done_reg) begin
          data_reg <= hwdata[7:0];
          wcol_reg <= 1'b0;
        end else begin
          wcol_reg <= 1'b1;
        end
      end
      ev_reg <= 3'h0;
      // Dispatch on a flag-clearing write, a stop request first
      if (go) begin
        ph_reg <= 2'h0;
        bit_reg <= 4'h0;
        case (w_sto ? 8'h00 : code_reg)
          `TWMR_SC_START, `TWMR_SC_RSTART: begin
            st_reg <= S_BYTE;
            tx_reg <= 1'b1;
            addr_reg <= 1'b1;
            sh_reg <= data_reg; // [RULE11]
          end
          `TWMR_SC_RACK, `TWMR_SC_DACK: begin
            st_reg <= S_BYTE; // [RULE13]
            tx_reg <= 1'b0;
            addr_reg <= 1'b0;
          end
          default: begin
            if (owned_reg && w_sto) begin
              st_reg <= S_STOP; // [RULE14]
              restart_reg <= w_sta;
            end else if (w_sta) begin
              st_reg <= S_START; // [RULE12] [RULE10]
            end else if (owned_reg) begin
              st_reg <= S_HOLD; // [RULE19]
            end else begin
              st_reg <= S_IDLE; // [RULE12]
              code_reg <= `TWMR_SC_IDLE;
            end
          end
        endcase
      end else if (wr_ctrl && !hwdata[`TWMR_CB_EN]) begin
        st_reg <= S_IDLE;
        scl_low_reg <= 1'b0;
        sda_low_reg <= 1'b0;
        owned_reg <= 1'b0;
        code_reg <= `TWMR_SC_IDLE;
      end else if (tick_reg) begin
        case (st_reg)
          S_START: begin
            case (ph_reg)
              2'h0: begin
                sda_low_reg <= 1'b0;
                if (owned_reg || !busy_reg)
                  ph_reg <= 2'h1; // [RULE2]
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                ph_reg <= 2'h2;
              end
              2'h2: begin
                if (scl_f_reg && sda_f_reg) begin
                  sda_low_reg <= 1'b1;
                  ph_reg <= 2'h3;
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                owned_reg <= 1'b1;
                code_reg <= owned_reg ? `TWMR_SC_RSTART :
                  `TWMR_SC_START; // [RULE3] [RULE10]
                done_reg <= 1'b1;
                ev_reg[`TWMR_IB_DONE] <= 1'b1;
                st_reg <= S_HOLD;
              end
            endcase
          end
          S_BYTE: begin
            case (ph_reg)
              2'h0: begin
                if (bit_reg == 4'h8)
                  sda_low_reg <= tx_reg ? 1'b0 : ack_en_reg; // [RULE13]
                else
                  sda_low_reg <= tx_reg ? ~sh_reg[7] : 1'b0;
                ph_reg <= 2'h1;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                ph_reg <= 2'h2;
              end
              2'h2: begin
                if (scl_f_reg) begin
                  if (drv_one && !sda_f_reg) begin
                    st_reg <= S_IDLE;
                    sda_low_reg <= 1'b0;
                    owned_reg <= 1'b0;
                    code_reg <= `TWMR_SC_ARB; // [RULE6]
                    done_reg <= 1'b1;
                    ev_reg <= 3'h3;
                  end else begin
                    if (bit_reg == 4'h8)
                      ack_bit_reg <= ~sda_f_reg;
                    else
                      sh_reg <= {sh_reg[6:0], sda_f_reg};
                    ph_reg <= 2'h3;
                  end
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                ph_reg <= 2'h0;
                if (bit_reg != 4'h8) begin
                  bit_reg <= bit_reg + 1'b1;
                end else begin
                  st_reg <= S_HOLD; // [RULE19]
                  done_reg <= 1'b1;
                  ev_reg[`TWMR_IB_DONE] <= 1'b1;
                  sda_low_reg <= 1'b0;
                  if (addr_reg) begin
                    rx_mode_reg <= sh_reg[0]; // [RULE4]
                    if (sh_reg[0])
                      code_reg <= ack_bit_reg ? `TWMR_SC_RACK :
                        `TWMR_SC_RNACK; // [RULE6]
                    else
                      code_reg <= ack_bit_reg ? `TWMR_SC_WACK :
                        `TWMR_SC_WNACK;
                  end else begin
                    data_reg <= sh_reg; // [RULE7]
                    code_reg <= ack_en_reg ? `TWMR_SC_DACK :
                      `TWMR_SC_DNACK;
                  end
                end
              end
            endcase
          end
          S_STOP: begin
            case (ph_reg)
              2'h0: begin
                sda_low_reg <= 1'b1;
                ph_reg <= 2'h1;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
                ph_reg <= 2'h2;
              end
              2'h2: begin
                if (scl_f_reg) begin
                  sda_low_reg <= 1'b0;
                  ph_reg <= 2'h3;
                end
              end
              default: begin
                owned_reg <= 1'b0;
                sto_reg <= 1'b0; // [RULE15]
                ev_reg[`TWMR_IB_STOP] <= 1'b1;
                code_reg <= `TWMR_SC_IDLE;
                ph_reg <= 2'h0;
                st_reg <= restart_reg ? S_START : S_IDLE; // [RULE14]
              end
            endcase
          end
          S_HOLD: scl_low_reg <= 1'b1; // [RULE19]
          S_IDLE: scl_low_reg <= 1'b0;
          default: st_reg <= S_IDLE;
        endcase
      end
    end
  end
endmodule

//--- twmr_properties.sv
// Purpose: Port properties of the two-wire master receiver
// Assumes: Only the done event is ever unmasked
// Notes: Bound to every twmr_top
`include "twmr_consts.vh"
module twmr_props (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire scl_i,
  input wire sda_i,
  input wire scl_oe_n,
  input wire sda_oe_n,
  input wire irq
);
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property
    (rd_take && haddr[7:0] > 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_istat_clear: assert property
    (rd_take && haddr[7:0] == `TWMR_OFF_ISTAT |-> ##2 !irq)
    else $error("irq still high after status read");
  a_start_free: assert property
    ($fell(sda_oe_n) && scl_oe_n |-> $past(sda_i) && scl_i)
    else $error("start on a busy bus");
  a_start_hold: assert property
    ($fell(sda_oe_n) && scl_oe_n |=> !sda_oe_n [*8])
    else $error("start condition too short");
  a_stop_release: assert property
    ($rose(sda_oe_n) && scl_oe_n |=> (sda_oe_n && scl_oe_n) [*8])
    else $error("bus not released after stop");
  a_irq_clk_low: assert property ($rose(irq) |-> !scl_oe_n [*8])
    else $error("clock not held low while done");
endmodule
bind twmr_top twmr_props chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .scl_i(scl_i), .sda_i(sda_i), .scl_oe_n(scl_oe_n),
  .sda_oe_n(sda_oe_n), .irq(irq));

//--- twmr_slave_model.sv
// Purpose: Slave transmitter on the two wires
// Assumes: Both wires have pull-ups; the master makes the clock
// Notes: Sends data, data+1, ... until the master returns NACK
module twmr_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] DATA = 8'ha5
) (
  input wire scl,
  input wire sda,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] val;
  logic more;
  initial begin
    sda_rel = 1'b1;
    sh = 8'h00;
    forever begin
      @(negedge sda iff scl === 1'b1);
      for (int i = 0; i < 8; i++) begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      @(negedge scl);
      if (sh == {ADDR, 1'b1}) begin
        sda_rel <= 1'b0;
        val = DATA;
        more = 1'b1;
        while (more) begin
          for (int i = 7; i >= 0; i--) begin
            @(negedge scl);
            sda_rel <= val[i];
          end
          @(negedge scl);
          sda_rel <= 1'b1;
          @(posedge scl);
          more = !sda;
          val = val + 8'h01;
        end
      end
    end
  end
endmodule

//--- two_wire_master_receiver_bench.sv
// Purpose: Register-level tests of the two-wire master receiver
// Assumes: One slave model at address 0x2a on the wires
// Notes: Only the done interrupt is unmasked
`include "twmr_consts.vh"
module two_wire_master_receiver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] oc = `TWMR_OFF_CTRL;
  localparam logic [7:0] od = `TWMR_OFF_DATA;
  localparam logic [7:0] oi = `TWMR_OFF_ISTAT;
  localparam logic [7:0] om = `TWMR_OFF_IMASK;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  wire [31:0] hrdata;
  wire hready, scl_oe_n, sda_oe_n, irq, sda_rel;
  wire scl = scl_oe_n;
  wire sda = sda_oe_n & sda_rel;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] exp_is = 32'h1;
  twmr_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(),
    .hrdata(hrdata), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n), .irq(irq));
  twmr_slave_model slv (.scl(scl), .sda(sda), .sda_rel(sda_rel));
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task st(input logic [31:0] exp);
    ahb(1'b0, `TWMR_OFF_STAT, 32'h0);
    chk(rd & 32'hf8, exp);
  endtask
  task wait_done;
    while (irq !== 1'b1) @(posedge hclk);
    chk({31'h0, scl_oe_n}, 32'h0);
    rchk(oi, exp_is);
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    forever begin
      @(posedge hclk);
      cyc++;
      if (cyc == 99000) begin
        n_fail++;
        give_verdict;
      end
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(oc, 32'h0);
    rchk(od, 32'hff);
    st(32'hf8);
    rchk(om, 32'h0);
    rchk(8'h14, 32'h0);
    ahb(1'b1, om, 32'h1);
    ahb(1'b1, oc, 32'ha4);
    wait_done;
    st(32'h08);
    ahb(1'b1, od, 32'h55);
    ahb(1'b1, oc, 32'h84);
    wait_done;
    st(32'h40);
    ahb(1'b1, oc, 32'hc4);
    wait_done;
    st(32'h50);
    rchk(od, 32'ha5);
    ahb(1'b1, oc, 32'h84);
    wait_done;
    st(32'h58);
    rchk(od, 32'ha6);
    ahb(1'b1, oc, 32'ha4);
    wait_done;
    st(32'h10);
    ahb(1'b1, od, 32'h57);
    ahb(1'b1, oc, 32'h84);
    wait_done;
    st(32'h48);
    ahb(1'b1, oc, 32'hb4);
    // Stop then start: the stop event is pending with the done event
    exp_is = 32'h5;
    wait_done;
    st(32'h08);
    ahb(1'b1, oc, 32'h94);
    rd = 32'h10;
    for (int i = 0; i < 3000 && rd[4]; i++)
      ahb(1'b0, oc, 32'h0);
    chk(rd & 32'h10, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(oi, 32'h4);
    give_verdict;
  end
endmodule
